// File: rtl/dcw_pkg.sv
package dcw_pkg;

   // Clocking and timer rates
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned TIMER_HZ = 32_768;
   localparam logic [31:0] TICK_INC =
      32'((64'(TIMER_HZ) << 32) / 64'(CLK_HZ));
   localparam int unsigned PERIOD_SHIFT = 2;
   localparam int unsigned CNT_W = 40;

   // Battery threshold scale in mV
   localparam logic [11:0] BATT_BASE_MV = 12'd1500;
   localparam logic [11:0] BATT_STEP_MV = 12'd50;

   // Register byte offsets
   localparam logic [7:0] REG_CONFIG = 8'h00;
   localparam logic [7:0] REG_PERIOD = 8'h04;
   localparam logic [7:0] REG_WINDOW = 8'h08;
   localparam logic [7:0] REG_THRESH = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_MASK = 8'h14;
   localparam logic [7:0] REG_STATE = 8'h18;

   // Field positions
   localparam int unsigned CFG_W = 6;
   localparam int unsigned PER_EXP_LSB = 16;
   localparam int unsigned ST_WUT = 0;
   localparam int unsigned ST_TX = 1;
   localparam int unsigned ST_LBAT = 2;
   localparam int unsigned ST_RXPKT = 3;
   localparam int unsigned ST_RXTO = 4;
   localparam int unsigned ST_W = 5;

   // Reset values
   localparam logic [5:0] RST_CONFIG = 6'h00;
   localparam logic [15:0] RST_MANT = 16'h0001;
   localparam logic [3:0] RST_EXP = 4'h0;
   localparam logic [7:0] RST_WIN = 8'h01;
   localparam logic [4:0] RST_THRESH = 5'h00;
   localparam logic [4:0] RST_MASK = 5'h00;

   typedef enum logic [1:0] {DCW_OFF, DCW_WAIT, DCW_RX, DCW_TX} dcw_state_e;

   typedef struct packed {
      logic idle_sleep;
      logic bat_gpio;
      logic bat_en;
      logic tx_mode;
      logic rx_mode;
      logic wut_en;
   } dcw_cfg_s;

   typedef struct packed {
      logic preamble;
      logic sync;
      logic pkt_valid;
      logic rx_err;
      logic tx_done;
   } dcw_radio_s;

   // Timer ticks for count x 4 x 2^exp
   function automatic logic [CNT_W-1:0] period_ticks(
      input logic [15:0] count, input logic [3:0] expo);
      logic [CNT_W-1:0] t;
      t = CNT_W'(count) << (5'(expo) + 5'(PERIOD_SHIFT));
      if (t == '0) begin
         t = CNT_W'(1);
      end
      return t;
   endfunction : period_ticks

   function automatic logic [11:0] thresh_mv(input logic [4:0] code);
      return BATT_BASE_MV + 12'(BATT_STEP_MV * 12'(code));
   endfunction : thresh_mv

endpackage : dcw_pkg

// File: rtl/dcw_tick.sv
`timescale 1ns/10ps
module dcw_tick import dcw_pkg::*; (
   // Clock and reset
   input logic pclk,
   input logic presetn,
   // Timer tick
   output logic tick
);
   typedef struct packed {
      logic [31:0] acc;
      logic tick;
   } dcw_tick_s;

   dcw_tick_s s_r;
   dcw_tick_s s_nxt;

   // Phase accumulator gives a 32.768 kHz tick on average
   always_comb begin
      logic [32:0] sum;
      sum = 33'(s_r.acc) + 33'(TICK_INC);
      s_nxt.acc = sum[31:0];
      s_nxt.tick = sum[32];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tick = s_r.tick;
endmodule : dcw_tick

// File: rtl/dcw_cnt.sv
`timescale 1ns/10ps
module dcw_cnt import dcw_pkg::*; (
   // Clock and reset
   input logic pclk,
   input logic presetn,
   // Control
   input logic tick,
   input logic run,
   input logic load,
   input logic [CNT_W-1:0] load_val,
   // Expiry pulse
   output logic done
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic done;
   } dcw_cnt_s;

   dcw_cnt_s s_r;
   dcw_cnt_s s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      if (load) begin
         s_nxt.cnt = load_val;
      end else if (run && tick && s_r.cnt != '0) begin
         s_nxt.cnt = s_r.cnt - CNT_W'(1);
         s_nxt.done = (s_r.cnt == CNT_W'(1));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign done = s_r.done;
endmodule : dcw_cnt

// File: rtl/dcw_top.sv
// Contract
// - Window length is count times 4*2^exp ticks
// - Receive mode: receiver on for one window
// - No preamble, sync or packet: back idle
// - Preamble or sync detect extends the window
// - No packet after two windows: back idle
// - Transmit mode: send buffered packet each wake
// - Transmit done drives interrupt if enabled
// - After transmit return idle until next wake
// - Battery checks only while timer enabled
// - Each expiry compares battery with threshold
// - Threshold 1.5 V to 3.05 V, 50 mV steps
// - Low battery goes to interrupt or GPIO
// - Wake period is mantissa times 4*2^exp ticks
// - Expiry raises interrupt if chip-enabled
`timescale 1ns/10ps
module dcw_top import dcw_pkg::*; (
   // Clock and reset
   input logic pclk,
   input logic presetn,
   // APB slave
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [31:0] paddr,
   input logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Radio events and battery measurement
   input dcw_radio_s radio_ev,
   input logic [11:0] batt_mv,
   // Radio control
   output logic rx_on,
   output logic tx_on,
   output logic radio_sleep,
   // Host notification
   output logic host_interrupt_line_n,
   output logic lowbatt_gpio
);
   typedef struct packed {
      dcw_radio_s ev_m;
      dcw_radio_s ev_s;
      logic [11:0] bat_m;
      logic [11:0] bat_s;
      dcw_cfg_s cfg;
      logic [15:0] mant;
      logic [3:0] expo;
      logic [7:0] win;
      logic [4:0] thresh;
      logic [4:0] status;
      logic [4:0] mask;
      dcw_state_e st;
      logic ext;
      logic second;
      logic per_run;
      logic rx_on;
      logic tx_on;
      logic sleep;
      logic irq_n;
      logic gpio;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } dcw_main_s;

   localparam dcw_main_s MAIN_RST = '{
      ev_m: '0, ev_s: '0, bat_m: '0, bat_s: '0,
      cfg: dcw_cfg_s'(RST_CONFIG), mant: RST_MANT, expo: RST_EXP,
      win: RST_WIN, thresh: RST_THRESH, status: '0, mask: RST_MASK,
      st: DCW_OFF, ext: 1'b0, second: 1'b0, per_run: 1'b0,
      rx_on: 1'b0, tx_on: 1'b0, sleep: 1'b0, irq_n: 1'b1,
      gpio: 1'b0, pready: 1'b0, pslverr: 1'b0, prdata: '0};

   dcw_main_s s_r;
   dcw_main_s s_nxt;
   logic tick;
   logic per_done;
   logic win_done;
   logic per_load;
   logic win_load;
   logic wake;
   logic bat_low;
   logic [4:0] set_ev;

   dcw_tick u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick)
   );

   // Wake period counter, reloaded at every expiry while the timer is enabled
   dcw_cnt u_period (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .run(s_r.cfg.wut_en),
      .load(per_load),
      .load_val(period_ticks(s_r.mant, s_r.expo)),
      .done(per_done)
   );

   // Receive window counter
   dcw_cnt u_window (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .run(s_r.st == DCW_RX),
      .load(win_load),
      .load_val(period_ticks({8'h00, s_r.win}, s_r.expo)),
      .done(win_done)
   );

   assign per_load = s_r.cfg.wut_en & (~s_r.per_run | per_done);
   assign wake = per_done;
   assign bat_low = s_r.bat_s < thresh_mv(s_r.thresh);

   always_comb begin
      s_nxt = s_r;
      set_ev = '0;
      win_load = 1'b0;
      s_nxt.ev_m = radio_ev;
      s_nxt.ev_s = s_r.ev_m;
      s_nxt.bat_m = batt_mv;
      s_nxt.bat_s = s_r.bat_m;
      s_nxt.per_run = s_r.cfg.wut_en;

      // Expiry events; an expiry can still land in the cycle after the timer is turned off
      if (wake) begin
         set_ev[ST_WUT] = 1'b1;
         if (s_r.cfg.bat_en && s_r.cfg.wut_en) begin
            if (s_r.cfg.bat_gpio) begin
               s_nxt.gpio = bat_low;
            end else begin
               set_ev[ST_LBAT] = bat_low;
            end
         end
      end

      case (s_r.st)
         DCW_OFF: begin
            if (s_r.cfg.wut_en) begin
               s_nxt.st = DCW_WAIT;
            end
         end
         DCW_WAIT: begin
            if (!s_r.cfg.wut_en) begin
               s_nxt.st = DCW_OFF;
            end else if (wake && s_r.cfg.tx_mode) begin
               s_nxt.st = DCW_TX;
               s_nxt.tx_on = 1'b1;
            end else if (wake && s_r.cfg.rx_mode) begin
               s_nxt.st = DCW_RX;
               s_nxt.rx_on = 1'b1;
               s_nxt.ext = 1'b0;
               s_nxt.second = 1'b0;
               win_load = 1'b1;
            end
         end
         DCW_RX: begin
            if (s_r.ev_s.pkt_valid) begin
               set_ev[ST_RXPKT] = 1'b1;
               s_nxt.rx_on = 1'b0;
               s_nxt.st = DCW_WAIT;
            end else begin
               if (s_r.ev_s.rx_err) begin
                  s_nxt.ext = 1'b0;
               end else if (s_r.ev_s.preamble || s_r.ev_s.sync) begin
                  s_nxt.ext = 1'b1;
               end
               if (win_done) begin
                  if (s_r.ext && !s_r.second) begin
                     s_nxt.second = 1'b1;
                     win_load = 1'b1;
                  end else begin
                     set_ev[ST_RXTO] = s_r.second;
                     s_nxt.rx_on = 1'b0;
                     s_nxt.st = DCW_WAIT;
                  end
               end
            end
         end
         DCW_TX: begin
            if (s_r.ev_s.tx_done) begin
               set_ev[ST_TX] = 1'b1;
               s_nxt.tx_on = 1'b0;
               s_nxt.st = DCW_WAIT;
            end
         end
         default: begin
            s_nxt.st = DCW_OFF;
         end
      endcase

      // APB: pready rises one cycle after setup
      s_nxt.pready = psel & ~penable;
      if (psel && !penable) begin
         s_nxt.pslverr = 1'b0;
         s_nxt.prdata = '0;
         if (paddr[7:0] == REG_CONFIG) begin
            s_nxt.prdata = 32'(s_r.cfg);
         end else if (paddr[7:0] == REG_PERIOD) begin
            s_nxt.prdata = {12'h000, s_r.expo, s_r.mant};
         end else if (paddr[7:0] == REG_WINDOW) begin
            s_nxt.prdata = 32'(s_r.win);
         end else if (paddr[7:0] == REG_THRESH) begin
            s_nxt.prdata = 32'(s_r.thresh);
         end else if (paddr[7:0] == REG_STATUS) begin
            s_nxt.prdata = 32'(s_r.status);
         end else if (paddr[7:0] == REG_MASK) begin
            s_nxt.prdata = 32'(s_r.mask);
         end else if (paddr[7:0] == REG_STATE) begin
            s_nxt.prdata = {27'h0000000, s_r.gpio, s_r.second, s_r.ext,
                            s_r.st};
         end else begin
            s_nxt.pslverr = 1'b1;
         end
         if (paddr[31:8] != 24'h000000) begin
            s_nxt.pslverr = 1'b1;
            s_nxt.prdata = '0;
         end
      end

      // Sticky status: hardware set wins over a write-one clear
      s_nxt.status = s_r.status | set_ev;
      if (psel && penable && s_r.pready && pwrite && !s_r.pslverr) begin
         if (paddr[7:0] == REG_CONFIG) begin
            s_nxt.cfg = dcw_cfg_s'(pwdata[CFG_W-1:0]);
         end else if (paddr[7:0] == REG_PERIOD) begin
            s_nxt.mant = pwdata[15:0];
            s_nxt.expo = pwdata[PER_EXP_LSB +: 4];
         end else if (paddr[7:0] == REG_WINDOW) begin
            s_nxt.win = pwdata[7:0];
         end else if (paddr[7:0] == REG_THRESH) begin
            s_nxt.thresh = pwdata[4:0];
         end else if (paddr[7:0] == REG_STATUS) begin
            s_nxt.status = (s_r.status & ~pwdata[ST_W-1:0]) | set_ev;
         end else if (paddr[7:0] == REG_MASK) begin
            s_nxt.mask = pwdata[ST_W-1:0];
         end
      end

      s_nxt.irq_n = ~|(s_nxt.status & s_nxt.mask);
      s_nxt.sleep = s_nxt.cfg.idle_sleep & ~s_nxt.rx_on & ~s_nxt.tx_on;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= MAIN_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign pready = s_r.pready;
   assign prdata = s_r.prdata;
   assign pslverr = s_r.pslverr;
   assign rx_on = s_r.rx_on;
   assign tx_on = s_r.tx_on;
   assign radio_sleep = s_r.sleep;
   assign host_interrupt_line_n = s_r.irq_n;
   assign lowbatt_gpio = s_r.gpio;

   // Checks
   sequence s_tx_finish;
      s_r.st == DCW_TX && s_r.ev_s.tx_done;
   endsequence

   sequence s_rx_wake;
      s_r.st == DCW_WAIT && wake && s_r.cfg.wut_en && s_r.cfg.rx_mode
         && !s_r.cfg.tx_mode;
   endsequence

   a_tx_idle: assert property (@(posedge pclk) disable iff (!presetn)
      s_tx_finish |=> s_r.st == DCW_WAIT && !tx_on)
      else $error("transmit did not return idle");

   a_tx_irq: assert property (@(posedge pclk) disable iff (!presetn)
      s_tx_finish ##0 s_r.mask[ST_TX] |=> !host_interrupt_line_n)
      else $error("transmit done without interrupt");

   a_tx_wake: assert property (@(posedge pclk) disable iff (!presetn)
      s_r.st == DCW_WAIT && wake && s_r.cfg.wut_en && s_r.cfg.tx_mode
      |=> tx_on && s_r.st == DCW_TX)
      else $error("transmit not started at wake");

   a_rx_wake: assert property (@(posedge pclk) disable iff (!presetn)
      s_rx_wake |=> rx_on ##1 s_r.st == DCW_RX)
      else $error("receiver not woken");

   a_win_end: assert property (@(posedge pclk) disable iff (!presetn)
      s_r.st == DCW_RX && win_done && !s_r.ext && !s_r.ev_s.pkt_valid
      |=> s_r.st == DCW_WAIT && !rx_on)
      else $error("window end did not idle");

   a_rx_extend: assert property (@(posedge pclk) disable iff (!presetn)
      s_r.st == DCW_RX && win_done && s_r.ext && !s_r.second
      && !s_r.ev_s.pkt_valid |=> s_r.st == DCW_RX && s_r.second && rx_on)
      else $error("window not extended");

   a_two_win: assert property (@(posedge pclk) disable iff (!presetn)
      s_r.st == DCW_RX && win_done && s_r.second && !s_r.ev_s.pkt_valid
      |=> s_r.st == DCW_WAIT && s_r.status[ST_RXTO])
      else $error("second window did not end receive");

   a_batt_off: assert property (@(posedge pclk) disable iff (!presetn)
      !s_r.cfg.wut_en && !s_r.per_run |-> !per_done)
      else $error("expiry with timer disabled");

   a_batt_cmp: assert property (@(posedge pclk) disable iff (!presetn)
      wake && s_r.cfg.bat_en && !s_r.cfg.bat_gpio && bat_low
      |=> s_r.status[ST_LBAT])
      else $error("low battery not flagged");

   a_irq_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !host_interrupt_line_n && !(psel && penable && pwrite)
      |=> !host_interrupt_line_n)
      else $error("interrupt released without clear");

   a_wut_irq: assert property (@(posedge pclk) disable iff (!presetn)
      wake && s_r.mask[ST_WUT] |=> !host_interrupt_line_n)
      else $error("expiry without interrupt");

endmodule : dcw_top

// File: tb/dcw_radio_model.sv
`timescale 1ns/10ps
module dcw_radio_model import dcw_pkg::*; (
   // Clock
   input logic pclk,
   // Radio commands and on-air scenario
   input logic rx_on,
   input logic tx_on,
   input logic [1:0] mode,
   // Radio events
   output dcw_radio_s radio_ev
);
   int n = 0;

   // Lines released by the radio drop back to zero
   // Mode 1 preamble only; mode 2 sync, error, then packet
   always @(posedge pclk) begin
      n <= (rx_on || tx_on) ? n + 1 : 0;
      radio_ev.tx_done <= tx_on && n >= 20;
      radio_ev.preamble <= rx_on && mode == 2'd1 && n >= 10 && n < 14;
      radio_ev.sync <= rx_on && mode == 2'd2 && n >= 10 && n < 14;
      radio_ev.pkt_valid <= rx_on && mode == 2'd2 && n >= 40 && n < 44;
      radio_ev.rx_err <= rx_on && mode == 2'd2 && n >= 20 && n < 24;
   end
endmodule : dcw_radio_model

// File: tb/testbench.sv
`timescale 1ns/10ps
module testbench import dcw_pkg::*;;
   localparam int TK = 3052;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [31:0] paddr, pwdata, prdata, q, seed;
   dcw_radio_s radio_ev;
   logic [11:0] batt_mv;
   logic rx_on, tx_on, radio_sleep, irq_n, gpio;
   logic [1:0] rmode;
   int n_fail, checks_done, c;
   int cyc = 0;
   int exp_reg [7];

   dcw_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .radio_ev(radio_ev), .batt_mv(batt_mv), .rx_on(rx_on),
      .tx_on(tx_on), .radio_sleep(radio_sleep),
      .host_interrupt_line_n(irq_n), .lowbatt_gpio(gpio));
   dcw_radio_model radio_u (.pclk(pclk), .rx_on(rx_on), .tx_on(tx_on),
      .mode(rmode), .radio_ev(radio_ev));

   task end_sim;
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim

   task chk(input logic [31:0] got, input logic [31:0] want);
      checks_done++;
      if (got !== want) begin
         n_fail++;
         $display("[ERR] %0t got %h want %h", $time, got, want);
      end
   endtask : chk

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic int fmask(input logic [7:0] a);
      case (a)
         REG_CONFIG: return 'h3f;
         REG_PERIOD: return 'hfffff;
         REG_WINDOW: return 'hff;
         REG_THRESH, REG_MASK: return 'h1f;
         default: return 0;
      endcase
   endfunction : fmask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 50) begin
         n_fail++;
         $display("[ERR] %0t no pready", $time);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (w && fmask(a) != 0) begin
         exp_reg[a >> 2] = d & fmask(a);
      end
   endtask : apb

   task rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
      chk(q, exp_reg[a >> 2]);
   endtask : rd

   // Bounded wait on the receive or transmit command
   task wait_for(input logic rx, input logic v, input int lim);
      c = 0;
      while ((rx ? rx_on : tx_on) !== v && c < lim) begin
         @(negedge pclk);
         c++;
      end
      chk(32'(c < lim), 32'h1);
   endtask : wait_for

   task in_rng(input int lo, input int hi);
      chk(32'(c >= lo && c <= hi), 32'h1);
   endtask : in_rng

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 95000) begin
         n_fail++;
         end_sim;
      end
   end

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      batt_mv = 12'd1900;
      rmode = 2'd0;
      seed = 32'h931eca73;
      exp_reg = '{0, 1, 1, 0, 0, 0, 0};
      n_fail = 0;
      checks_done = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         rd(8'(i * 4));
      end
      seed = lfsr(seed);
      apb(1'b1, REG_STATE, seed);
      rd(REG_STATE);
      apb(1'b0, 8'h1c, 32'h0);
      chk(q, 32'h0);
      chk(32'(e), 32'h1);
      repeat (3) begin
         seed = lfsr(seed);
         apb(1'b1, REG_THRESH, seed);
         rd(REG_THRESH);
         apb(1'b1, REG_MASK, ~seed);
         rd(REG_MASK);
         apb(1'b1, REG_PERIOD, seed);
         rd(REG_PERIOD);
         apb(1'b1, REG_WINDOW, ~seed);
         rd(REG_WINDOW);
      end
      apb(1'b1, REG_PERIOD, 32'h1);
      apb(1'b1, REG_WINDOW, 32'h1);
      // Transmit wake, battery under threshold
      apb(1'b1, REG_THRESH, 32'd10);
      apb(1'b1, REG_MASK, 32'h2);
      apb(1'b1, REG_CONFIG, 32'h0d);
      wait_for(1'b0, 1'b1, 14000);
      wait_for(1'b0, 1'b0, 200);
      repeat (2) @(negedge pclk);
      chk(32'(irq_n), 32'h0);
      apb(1'b0, REG_STATUS, 32'h0);
      chk(q, 32'h3 | (32'(batt_mv < 1500 + 50 * 10) << 2));
      apb(1'b0, REG_STATE, 32'h0);
      chk(q & 32'h3, 32'h1);
      chk(32'(tx_on), 32'h0);
      chk(32'(irq_n), 32'h0);
      apb(1'b1, REG_STATUS, 32'h1f);
      repeat (2) @(negedge pclk);
      chk(32'(irq_n), 32'h1);
      // Receive window with nothing on air, idle in sleep
      apb(1'b1, REG_CONFIG, 32'h0);
      apb(1'b1, REG_THRESH, 32'd8);
      apb(1'b1, REG_MASK, 32'h1);
      apb(1'b1, REG_STATUS, 32'h1f);
      apb(1'b1, REG_CONFIG, 32'h3b);
      wait_for(1'b1, 1'b1, 14000);
      in_rng(3 * TK, 4 * TK + 20);
      repeat (3) @(negedge pclk);
      chk(32'(irq_n), 32'h0);
      chk(32'(gpio), 32'(batt_mv < 1500 + 50 * 8));
      wait_for(1'b1, 1'b0, 14000);
      in_rng(4 * TK - 20, 4 * TK + 20);
      repeat (2) @(negedge pclk);
      chk(32'(radio_sleep), 32'h1);
      // Preamble stretches the window, packet never completes
      apb(1'b1, REG_CONFIG, 32'h0);
      wait_for(1'b1, 1'b0, 14000);
      rmode <= 2'd1;
      apb(1'b1, REG_THRESH, 32'd9);
      apb(1'b1, REG_STATUS, 32'h1f);
      apb(1'b1, REG_CONFIG, 32'h1b);
      wait_for(1'b1, 1'b1, 14000);
      repeat (3) @(negedge pclk);
      chk(32'(gpio), 32'(batt_mv < 1500 + 50 * 9));
      wait_for(1'b1, 1'b0, 30000);
      in_rng(8 * TK - 30, 8 * TK + 30);
      apb(1'b0, REG_STATUS, 32'h0);
      chk(q & 32'h1c, 32'h10);
      // Sync stretches, an error drops the stretch, then a packet
      apb(1'b1, REG_STATUS, 32'h1f);
      rmode <= 2'd2;
      wait_for(1'b1, 1'b1, 14000);
      repeat (16) @(negedge pclk);
      apb(1'b0, REG_STATE, 32'h0);
      chk(q & 32'h4, 32'h4);
      repeat (8) @(negedge pclk);
      apb(1'b0, REG_STATE, 32'h0);
      chk(q & 32'h4, 32'h0);
      wait_for(1'b1, 1'b0, 200);
      apb(1'b0, REG_STATUS, 32'h0);
      chk(q & 32'h18, 32'h8);
      end_sim;
   end
endmodule : testbench
